// ==== src/chop_if.sv ====
// link between the register bank and the chopper time base
`timescale 1ns/1ps
`default_nettype none
interface chop_if;
  quiet_chopper_pkg::rate_sel_t rate_sel;
  logic                         cycle_pulse;
  modport bank     (output rate_sel, input cycle_pulse);
  modport timebase (input rate_sel, output cycle_pulse);
endinterface
`default_nettype wire

// ==== src/chop_timebase.sv ====
// chopper time base: two pwm cycles per selected period
`timescale 1ns/1ps
`include "quiet_chopper_regs.svh"
`default_nettype none
module chop_timebase (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  chop_if.timebase  link
);
  quiet_chopper_pkg::period_t cnt_reg;
  quiet_chopper_pkg::period_t cnt_next;
  quiet_chopper_pkg::period_t period;
  logic                       pulse_reg;
  wire                        at_half;

  assign period = (link.rate_sel == 2'h1) ? `PERIOD_RATE1 :   // R1
                  (link.rate_sel == 2'h2) ? `PERIOD_RATE2 :   // R1
                  (link.rate_sel == 2'h3) ? `PERIOD_RATE3 :   // R1
                                            `PERIOD_RATE0;    // R2
  assign cnt_next = (cnt_reg >= period - 11'h001) ? 11'h000 : cnt_reg + 11'h001;
  assign at_half  = (cnt_reg == (period >> 1)) || (cnt_reg == 11'h000);
  assign link.cycle_pulse = pulse_reg;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg   <= 11'h000;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      pulse_reg <= at_half;
    end
  end
endmodule // chop_timebase
`default_nettype wire

// ==== src/quiet_chopper_cfg_status.sv ====
// chopper configuration and driver status register bank
`timescale 1ns/1ps
`include "quiet_chopper_regs.svh"
`default_nettype none
module quiet_chopper_cfg_status #(
  parameter int STANDSTILL_CYCLES = `STANDSTILL_CLOCKS
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // register access
  input  wire logic [6:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // one-time memory seed
  input  wire logic        otp_grad_valid_in,
  input  wire logic [7:0]  otp_grad_in,
  // motor side
  input  wire logic        step_pin_in,
  input  wire logic [19:0] step_interval_in,
  input  wire logic        quiet_mode_in,
  input  wire logic [4:0]  run_current_in,
  input  wire logic [4:0]  hold_current_in,
  input  wire logic [7:0]  auto_amplitude_in,
  input  wire logic [7:0]  lower_threshold_in,
  input  wire logic [7:0]  learned_gradient_in,
  // chopper outputs
  output logic             pwm_cycle_out,
  output logic      [7:0]  pwm_amplitude_out,
  output logic      [4:0]  cs_actual_out,
  output logic             autoscale_out,
  output logic             standstill_out
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration fields
  logic [7:0]                   amplitude_offset_reg;
  logic [7:0]                   amplitude_gradient_reg;
  quiet_chopper_pkg::rate_sel_t chop_rate_sel_reg;
  logic                         autoscale_reg;
  logic                         init_done_reg;
  wire                          cfg_wr = reg_wr_in && (reg_addr_in == `CONFIG_OFFSET);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      amplitude_offset_reg   <= `OFS_RESET;                    // R7
      amplitude_gradient_reg <= `GRAD_RESET;
      chop_rate_sel_reg      <= `RATE_RESET;
      autoscale_reg          <= `AUTOSCALE_RESET;              // R14
      init_done_reg          <= 1'b0;
    end else if (!init_done_reg) begin
      init_done_reg <= 1'b1;
      if (otp_grad_valid_in) begin
        amplitude_gradient_reg <= otp_grad_in;                 // R5
      end
    end else if (cfg_wr) begin
      amplitude_offset_reg   <= reg_wdata_in[`CFG_OFS_LSB +: 8];   // R7
      amplitude_gradient_reg <= reg_wdata_in[`CFG_GRAD_LSB +: 8];  // R3
      chop_rate_sel_reg      <= reg_wdata_in[`CFG_RATE_LSB +: 2];  // R1
      autoscale_reg          <= reg_wdata_in[`CFG_AUTOSCALE_BIT];  // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base
  chop_if link ();
  assign link.rate_sel = chop_rate_sel_reg;
  chop_timebase u_timebase (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .link    (link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // step synchroniser and standstill timer
  logic        step_meta_reg;
  logic        step_sync_reg;
  logic        step_prev_reg;
  logic [20:0] idle_cnt_reg;
  logic        standstill_reg;
  wire         step_edge = step_sync_reg && !step_prev_reg;
  wire         idle_done = (idle_cnt_reg >= 21'(STANDSTILL_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step_meta_reg  <= 1'b0;
      step_sync_reg  <= 1'b0;
      step_prev_reg  <= 1'b0;
      idle_cnt_reg   <= 21'h00_0000;
      standstill_reg <= 1'b0;
    end else begin
      step_meta_reg <= step_pin_in;
      step_sync_reg <= step_meta_reg;
      step_prev_reg <= step_sync_reg;
      if (step_edge) begin
        idle_cnt_reg   <= 21'h00_0000;
        standstill_reg <= 1'b0;
      end else if (idle_done) begin
        standstill_reg <= 1'b1;                                // R11
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 21'h00_0001;            // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // amplitude computation
  wire [4:0]  scale_sel  = standstill_reg ? hold_current_in : run_current_in;
  wire [4:0]  cs_applied = autoscale_reg ? scale_sel : `FULL_SCALE;          // R14
  wire [13:0] base_prod  = 14'(amplitude_offset_reg * ({1'b0, cs_applied} + 6'h01));
  wire [8:0]  base_amp   = base_prod[13:5];
  wire [15:0] grad_shift = {amplitude_gradient_reg, 8'h00};
  wire [19:0] velo_div   = (step_interval_in == 20'h0_0000) ? 20'hf_ffff :
                           20'({4'h0, grad_shift} / step_interval_in);      // R3
  wire [8:0]  velo_term  = (velo_div > 20'h0_00ff) ? 9'h0ff : velo_div[8:0];
  wire [9:0]  ff_sum     = {1'b0, base_amp} + {1'b0, velo_term};            // R3
  wire [7:0]  ff_amp     = (ff_sum > 10'h0ff) ? `AMP_MAX : ff_sum[7:0];
  wire        below_thr  = auto_amplitude_in < lower_threshold_in;
  wire [7:0]  auto_amp   = ((amplitude_offset_reg == 8'h00) && below_thr) ?
                           lower_threshold_in :                              // R9
                           auto_amplitude_in;                                // R10
  wire [7:0]  amp_sel    = autoscale_reg ? auto_amp : ff_amp;                // R14

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_cycle_out     <= 1'b0;
      pwm_amplitude_out <= 8'h00;
      cs_actual_out     <= 5'h00;
      autoscale_out     <= 1'b0;
      standstill_out    <= 1'b0;
    end else begin
      pwm_cycle_out  <= link.cycle_pulse;
      cs_actual_out  <= cs_applied;
      autoscale_out  <= autoscale_reg;
      standstill_out <= standstill_reg;
      if (link.cycle_pulse) begin
        pwm_amplitude_out <= amp_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back
  wire [31:0] status_word = {standstill_reg,                                 // R11
                             quiet_mode_in,                                  // R12
                             9'h000,                                         // R15
                             cs_applied,                                     // R13
                             16'h0000};                                      // R15
  wire [31:0] config_word = {13'h0000, autoscale_reg, chop_rate_sel_reg,
                             amplitude_gradient_reg, amplitude_offset_reg};
  wire [31:0] learned_word = {24'h00_0000, learned_gradient_in};             // R6
  wire [31:0] rd_sel = (reg_addr_in == `STATUS_OFFSET)  ? status_word  :
                       (reg_addr_in == `CONFIG_OFFSET)  ? config_word  :
                       (reg_addr_in == `LEARNED_OFFSET) ? learned_word :
                                                          32'h0000_0000;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_sel;
    end
  end
endmodule // quiet_chopper_cfg_status
`default_nettype wire

// ==== src/quiet_chopper_pkg.sv ====
// types shared by the quiet chopper bank
package quiet_chopper_pkg;
  typedef logic [1:0]  rate_sel_t;
  typedef logic [4:0]  cur_scale_t;
  typedef logic [7:0]  amp_t;
  typedef logic [10:0] period_t;
endpackage

// ==== src/quiet_chopper_regs.svh ====
// register offsets, field positions, reset values and timing counts of the quiet chopper bank
// Function
// (R1) rate codes 01, 10, 11 give 2/683, 2/512, 2/410 of clock
// (R2) rate code 00 gives 2/1024 of clock; upper rate bit is 17
// (R3) add gradient times 256 over step interval to base amplitude
// (R4) host seeds gradient with scaling off, then scaling on, then quiet chopper
// (R5) gradient from one-time memory is loaded at power-up
// (R6) learned gradient is readable after initial tuning
// (R7) offset field bits 7..0, range 0..255 at scale 31, resets to 36
// (R8) host seeds offset with scaling off, then scaling on, then quiet chopper
// (R9) zero offset keeps amplitude at or above lower measurement threshold
// (R10) nonzero offset lets scaling go below threshold, following hold scale
// (R11) standstill bit 31 sets 2^20 clocks after last step
// (R12) status bit 30 is one in quiet chopper, zero in cycle chopper
// (R13) status bits 20..16 show applied current scale
// (R14) bit 18 selects automatic scaling, default set; clear uses feed-forward
// (R15) reserved status bits read zero
`ifndef QUIET_CHOPPER_REGS_SVH
`define QUIET_CHOPPER_REGS_SVH

`define STATUS_OFFSET        7'h6f
`define CONFIG_OFFSET        7'h70
`define LEARNED_OFFSET       7'h71

`define CFG_OFS_LSB          0
`define CFG_GRAD_LSB         8
`define CFG_RATE_LSB         16
`define CFG_AUTOSCALE_BIT    18
`define CFG_USED_MSB         18

`define STS_STANDSTILL_BIT   31
`define STS_QUIET_BIT        30
`define STS_CS_LSB           16

`define OFS_RESET            8'h24
`define GRAD_RESET           8'h00
`define RATE_RESET           2'h1
`define AUTOSCALE_RESET      1'h1

`define PERIOD_RATE0         11'h400
`define PERIOD_RATE1         11'h2ab
`define PERIOD_RATE2         11'h200
`define PERIOD_RATE3         11'h19a

`define STANDSTILL_CLOCKS    (1 << 20)
`define FULL_SCALE           5'h1f
`define AMP_MAX              8'hff

`endif

// ==== tb/host_model.sv ====
// host side register access model
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  output logic      [6:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  initial begin
    addr_out = 7'h00;
    wdata_out = 32'h0000_0000;
    wr_out = 1'h0;
    rd_out = 1'h0;
  end
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge clk_in);
    wr_out <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'h1;
    @(posedge clk_in);
    rd_out <= 1'h0;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/quiet_chopper_sva.sv ====
// port assertions for the quiet chopper bank
`timescale 1ns/1ps
`default_nettype none
module quiet_chopper_sva #(parameter int STANDSTILL_CYCLES = 16) (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [6:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        step_pin_in,
  input wire logic        quiet_mode_in,
  input wire logic [4:0]  hold_current_in,
  input wire logic        pwm_cycle_out,
  input wire logic [7:0]  pwm_amplitude_out,
  input wire logic [4:0]  cs_actual_out,
  input wire logic        autoscale_out,
  input wire logic        standstill_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire sts_rd = reg_rd_in && reg_addr_in == 7'h6f;
  wire cfg_rd = reg_rd_in && reg_addr_in == 7'h70;
  sequence next_pulse_s; ##1 !pwm_cycle_out ##[0:511] pwm_cycle_out; endsequence
  pulse_spacing_a: assert property (pwm_cycle_out |-> next_pulse_s) else $error("pwm pulse spacing wrong");
  status_reserved_a: assert property (sts_rd |=> reg_rdata_out[29:21] == 9'h000 && reg_rdata_out[15:0] == 16'h0000)
    else $error("reserved status bits set");
  quiet_bit_a: assert property (sts_rd |=> reg_rdata_out[30] == $past(quiet_mode_in)) else $error("mode bit wrong");
  standstill_bit_a: assert property (sts_rd |=> reg_rdata_out[31] == standstill_out
    || reg_rdata_out[31] == $past(standstill_out)) else $error("standstill bit wrong");
  config_upper_a: assert property (cfg_rd |=> reg_rdata_out[31:19] == 13'h0000) else $error("config upper bits set");
  amp_update_a: assert property ($changed(pwm_amplitude_out) |-> pwm_cycle_out) else $error("amplitude off pulse");
  step_clear_a: assert property ($rose(step_pin_in) |-> ##[2:5] !standstill_out) else $error("step kept standstill");
  ff_scale_a: assert property (!autoscale_out [*2] |-> cs_actual_out == 5'h1f) else $error("scale not full");
  hold_scale_a: assert property ((autoscale_out && standstill_out) [*2] |-> cs_actual_out == $past(hold_current_in))
    else $error("hold scale missing");
endmodule // quiet_chopper_sva
bind quiet_chopper_cfg_status quiet_chopper_sva #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES)) chk (.*);
`default_nettype wire

// ==== tb/tb_quiet_chopper_cfg_status.sv ====
// self-checking bench for the quiet chopper bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module tb_quiet_chopper_cfg_status;
  logic        clk_in = 1'h0, rstn_in = 1'h0, step = 1'h0, quiet = 1'h0;
  logic [7:0]  auto_amp = 8'h10;
  logic [7:0]  lgrad = 8'h77;
  logic [19:0] step_interval = 20'h0_0040;
  logic [4:0]  hold_cs = 5'h03;
  logic [6:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        wr, rd, pulse, asc, stst;
  logic [7:0]  amp;
  logic [4:0]  cs;
  int          err_total = 0, tests_run = 0, cyc = 0, g0, g1;
  int          per [4] = '{1024, 683, 512, 410};
  always #5 clk_in = ~clk_in;
  host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  quiet_chopper_cfg_status #(.STANDSTILL_CYCLES(16)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .otp_grad_valid_in(1'h1),
    .otp_grad_in(8'h5a), .step_pin_in(step), .step_interval_in(step_interval), .quiet_mode_in(quiet),
    .run_current_in(5'h0c), .hold_current_in(hold_cs), .auto_amplitude_in(auto_amp), .lower_threshold_in(8'h30),
    .learned_gradient_in(lgrad), .pwm_cycle_out(pulse), .pwm_amplitude_out(amp), .cs_actual_out(cs),
    .autoscale_out(asc), .standstill_out(stst));
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (pulse !== 1'h1 && n < 2000);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    host.rd(7'h70, d); `CHK(d, 32'h0005_5a24)
    for (int i = 0; i < 4; i++) begin
      host.wr(7'h70, 32'hfff8_1020 | (32'(i) << 16));
      host.rd(7'h70, d); `CHK(d, 32'h0000_1020 | (32'(i) << 16))
      gap(g0);
      gap(g0);
      gap(g1);
      `CHK(g0 + g1, per[i])
      `CHK(amp, 8'h60)
      `CHK(cs, 5'h1f)
    end
    host.wr(7'h70, 32'h0004_0000);
    quiet <= 1'h1;
    gap(g0);
    gap(g0);
    `CHK(amp, 8'h30)
    host.wr(7'h70, 32'h0004_0001);
    gap(g0);
    gap(g0);
    `CHK(amp, 8'h10)
    @(posedge clk_in) step <= 1'h1;
    repeat (3) @(posedge clk_in);
    step <= 1'h0;
    host.rd(7'h6f, d); `CHK(d, 32'h400c_0000)
    repeat (30) @(posedge clk_in);
    host.rd(7'h6f, d); `CHK(d, 32'hc003_0000)
    host.rd(7'h71, d); `CHK(d, 32'h0000_0077)
    lgrad <= 8'h3c;
    host.rd(7'h71, d); `CHK(d, 32'h0000_003c)
    host.rd(7'h10, d); `CHK(d, 32'h0000_0000)
    report_and_stop;
  end
endmodule // tb_quiet_chopper_cfg_status
`default_nettype wire
